// >>> rtl/stc_pkg.sv
// Package for the scaler task and input control block: register map, fields, states.
package stc_pkg;

    // ************************************************************
    // Register subaddresses
    // ************************************************************
    localparam logic [7:0] STC_ADDR_STATUS      = 8'h8F;
    localparam logic [7:0] STC_ADDR_TASK_A      = 8'h90;
    localparam logic [7:0] STC_ADDR_FORMAT_A    = 8'h91;
    localparam logic [7:0] STC_ADDR_REF_A       = 8'h92;
    localparam logic [7:0] STC_ADDR_TASK_B      = 8'hC0;
    localparam logic [7:0] STC_ADDR_FORMAT_B    = 8'hC1;
    localparam logic [7:0] STC_ADDR_REF_B       = 8'hC2;

    // ************************************************************
    // Reset values and small constants
    // ************************************************************
    localparam logic [7:0] STC_TASK_RST         = 8'h00;
    localparam logic [7:0] STC_FORMAT_RST       = 8'h00;
    localparam logic [7:0] STC_REF_RST          = 8'h00;
    localparam logic [7:0] STC_RDATA_RST        = 8'h00;
    localparam logic [2:0] STC_SKIP_ZERO        = 3'h0;
    localparam logic [1:0] STC_LINE_ZERO        = 2'h0;
    localparam logic       STC_SET_A            = 1'b0;

    // Trigger select encodings
    localparam logic [1:0] STC_TRIG_IMMEDIATE   = 2'h0;
    localparam logic [1:0] STC_TRIG_VSYNC       = 2'h1;
    localparam logic [1:0] STC_TRIG_FIELD0      = 2'h2;
    localparam logic [1:0] STC_TRIG_FIELD1      = 2'h3;

    // ************************************************************
    // Register field layouts, msb first as in the byte
    // ************************************************************
    typedef struct packed {
        logic       task_flag_polarity;      // D7
        logic       output_field_id_select;  // D6
        logic [2:0] field_skip;              // D5..D3
        logic       task_repeat;             // D2
        logic [1:0] trigger_select;          // D1..D0
    } stc_task_cfg_t;

    typedef struct packed {
        logic       vgate_polarity;          // D7
        logic       fv_hold_sync;            // D6
        logic [1:0] source_select;           // D5..D4
        logic       request_mode_off;        // D3
        logic [1:0] chroma_line;             // D2..D1
        logic       sampling_scheme_select;  // D0
    } stc_format_cfg_t;

    typedef struct packed {
        logic       field_detect_edge;       // D7
        logic       field_id_mode;           // D6
        logic       vref_type;               // D5
        logic       vref_edge;               // D4
        logic [3:0] other_ref_bits;          // D3..D0, stored only
    } stc_ref_cfg_t;

    // Status byte, upper bits owned by other blocks read as zero
    typedef struct packed {
        logic [4:0] upper_zero;
        logic       formatter_error_flag;    // D2
        logic       input_field_id_status;   // D1
        logic       output_field_id_status;  // D0
    } stc_status_t;

    // Event handler states, Gray along wait-skip-run-done
    typedef enum logic [1:0] {
        STC_WAIT = 2'b00,
        STC_SKIP = 2'b01,
        STC_RUN  = 2'b11,
        STC_DONE = 2'b10
    } stc_state_t;

endpackage : stc_pkg

// >>> rtl/stc_scaler_task_ctrl.sv
// Scaler task sequencing, input source selection and X port reference handling.
//
// Overview of operation
// - Status bit D2 shows formatter error when rate conflict interrupts output.
// - Status bit D1 shows the field ID present at the scaler input.
// - Status bit D0 shows the field ID at the scaler output.
// - Status reads show live flag states, no read-time capture.
// - Output field ID follows input field ID, or a task-toggled flag.
// - Polarity bit sets timing-code bit 7 and task flag to 1, or 0.
// - Skip 0 to 7 fields before carrying out the active task.
// - Trigger: right after finish, next vsync, field ID 0, or field ID 1.
// - Repeat bit runs the active task once more before handover.
// - Source follows requests only if enable bit 0 and global request mode 1.
// - Two-bit source select chooses decoder (even codes) or X port (odd codes).
// - Hold bit synchronizes timing-code F and V bits to output line start.
// - Polarity bit inverts timing-code V bit and vertical gate pin.
// - Sampling bit picks 4:2:2-like or 4:1:1-like input interpretation.
// - Chroma expected every line, or every 2nd, 3rd or 4th line.
// - Edge bit picks rising or falling vertical reference edge.
// - Type bit treats reference as vsync/gate, or frame sync with both edges.
// - Field ID is horizontal ref at field edge, optionally inverted.
// - Field detection edge is falling or rising edge of vertical reference.
// - Two independent register sets A and B at separate subaddresses.
`timescale 1ns/1ps

module stc_scaler_task_ctrl
    import stc_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic        xclk,
    input  wire logic        xclk_rst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic [7:0]  reg_wdata,
    output logic [7:0]       reg_rdata,
    input  wire logic        ext_vertical_ref,
    input  wire logic        ext_horizontal_ref,
    input  wire logic        decoder_vertical_signal,
    input  wire logic        decoder_field_id,
    input  wire logic        global_request_mode,
    input  wire logic        output_rate_conflict,
    input  wire logic        internal_vgate,
    input  wire logic        output_line_start,
    input  wire logic        input_line_start,
    input  wire logic        task_done,
    output logic             task_start,
    output logic             active_set,
    output logic             task_flag,
    output logic             output_field_id,
    output logic             code_bit7,
    output logic             code_f_bit,
    output logic             code_v_bit,
    output logic             vgate_output_pin,
    output logic [1:0]       scaler_source,
    output logic             request_enable,
    output logic             sampling_411,
    output logic             chroma_line_valid
);

    // ************************************************************
    // Register sets A and B
    // ************************************************************
    stc_task_cfg_t   task_cfg_r   [2];
    stc_format_cfg_t format_cfg_r [2];
    stc_ref_cfg_t    ref_cfg_r    [2];

    // Decode of set index for a subaddress, used by the read-back only
    function automatic logic set_of(input logic [7:0] addr);
        set_of = (addr == STC_ADDR_TASK_B) || (addr == STC_ADDR_FORMAT_B) ||
                 (addr == STC_ADDR_REF_B);
    endfunction : set_of

    // Separate write ports per set so software can program the idle set
    genvar gs;
    generate
        for (gs = 0; gs < 2; gs++) begin : g_set
            logic [7:0] task_addr;
            logic [7:0] format_addr;
            logic [7:0] ref_addr;
            assign task_addr   = (gs == 0) ? STC_ADDR_TASK_A   : STC_ADDR_TASK_B;
            assign format_addr = (gs == 0) ? STC_ADDR_FORMAT_A : STC_ADDR_FORMAT_B;
            assign ref_addr    = (gs == 0) ? STC_ADDR_REF_A    : STC_ADDR_REF_B;

            // Register writes for one set
            always_ff @(posedge clock) begin
                if (sys_rst) begin
                    task_cfg_r[gs]   <= stc_task_cfg_t'(STC_TASK_RST);
                    format_cfg_r[gs] <= stc_format_cfg_t'(STC_FORMAT_RST);
                    ref_cfg_r[gs]    <= stc_ref_cfg_t'(STC_REF_RST);
                end else if (reg_wr) begin
                    if (reg_addr == task_addr) begin
                        task_cfg_r[gs] <= stc_task_cfg_t'(reg_wdata);
                    end else if (reg_addr == format_addr) begin
                        format_cfg_r[gs] <= stc_format_cfg_t'(reg_wdata);
                    end else if (reg_addr == ref_addr) begin
                        ref_cfg_r[gs] <= stc_ref_cfg_t'(reg_wdata);
                    end
                end
            end
        end
    endgenerate

    // Active set selects the configuration the logic works from
    logic            active_set_r;
    stc_task_cfg_t   tcfg;
    stc_format_cfg_t fcfg;
    stc_ref_cfg_t    rcfg;
    assign tcfg = task_cfg_r[active_set_r];
    assign fcfg = format_cfg_r[active_set_r];
    assign rcfg = ref_cfg_r[active_set_r];

    // ************************************************************
    // Link domain: X port vertical and horizontal references
    // ************************************************************
    logic       xv_s1_r, xv_s2_r, xv_d_r;
    logic       xh_s1_r, xh_s2_r;
    logic [2:0] xcfg_s1_r, xcfg_s2_r;
    logic       x_vsync_tgl_r;
    logic       x_fid_r;
    logic       xv_rise, xv_fall, x_vsync_evt, x_fid_edge;

    // Pins into two stages before any use
    always_ff @(posedge xclk) begin
        if (xclk_rst) begin
            xv_s1_r <= 1'b0;
            xv_s2_r <= 1'b0;
            xv_d_r  <= 1'b0;
            xh_s1_r <= 1'b0;
            xh_s2_r <= 1'b0;
        end else begin
            xv_s1_r <= ext_vertical_ref;
            xv_s2_r <= xv_s1_r;
            xv_d_r  <= xv_s2_r;
            xh_s1_r <= ext_horizontal_ref;
            xh_s2_r <= xh_s1_r;
        end
    end

    // Quasi-static reference configuration crosses bitwise as levels
    always_ff @(posedge xclk) begin
        if (xclk_rst) begin
            xcfg_s1_r <= '0;
            xcfg_s2_r <= '0;
        end else begin
            xcfg_s1_r <= {rcfg.field_detect_edge, rcfg.vref_type, rcfg.vref_edge};
            xcfg_s2_r <= xcfg_s1_r;
        end
    end

    assign xv_rise = xv_s2_r & ~xv_d_r;
    assign xv_fall = ~xv_s2_r & xv_d_r;
    // Frame sync gives a vertical pulse on both edges
    assign x_vsync_evt = xcfg_s2_r[1] ? (xv_rise | xv_fall)
                                      : (xcfg_s2_r[0] ? xv_fall : xv_rise);
    assign x_fid_edge  = xcfg_s2_r[2] ? xv_rise : xv_fall;

    // Field ID caught from horizontal ref level; vsync sent as a toggle
    always_ff @(posedge xclk) begin
        if (xclk_rst) begin
            x_fid_r       <= 1'b0;
            x_vsync_tgl_r <= 1'b0;
        end else begin
            if (x_fid_edge) begin
                x_fid_r <= xh_s2_r;
            end
            if (x_vsync_evt) begin
                x_vsync_tgl_r <= ~x_vsync_tgl_r;
            end
        end
    end

    // ************************************************************
    // System domain: crossings back and decoder references
    // ************************************************************
    logic xt_s1_r, xt_s2_r, xt_s3_r;
    logic xf_s1_r, xf_s2_r;
    logic dv_s1_r, dv_s2_r, dv_d_r;
    logic df_s1_r, df_s2_r;

    // Toggle has a third stage only for edge detection; its event and the field ID leave stage two in the same cycle
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            xt_s1_r <= 1'b0;
            xt_s2_r <= 1'b0;
            xt_s3_r <= 1'b0;
            xf_s1_r <= 1'b0;
            xf_s2_r <= 1'b0;
            dv_s1_r <= 1'b0;
            dv_s2_r <= 1'b0;
            dv_d_r  <= 1'b0;
            df_s1_r <= 1'b0;
            df_s2_r <= 1'b0;
        end else begin
            xt_s1_r <= x_vsync_tgl_r;
            xt_s2_r <= xt_s1_r;
            xt_s3_r <= xt_s2_r;
            xf_s1_r <= x_fid_r;
            xf_s2_r <= xf_s1_r;
            dv_s1_r <= decoder_vertical_signal;
            dv_s2_r <= dv_s1_r;
            dv_d_r  <= dv_s2_r;
            df_s1_r <= decoder_field_id;
            df_s2_r <= df_s1_r;
        end
    end

    logic src_is_xport;
    logic dec_vsync_evt;
    logic vsync_evt;
    logic in_fid;

    // Odd source codes come from the X port, even ones from the decoder
    assign src_is_xport  = fcfg.source_select[0];
    assign dec_vsync_evt = rcfg.vref_edge ? (~dv_s2_r & dv_d_r)
                                          : (dv_s2_r & ~dv_d_r);
    assign vsync_evt     = src_is_xport ? (xt_s2_r ^ xt_s3_r) : dec_vsync_evt;
    assign in_fid        = (src_is_xport ? xf_s2_r : df_s2_r) ^ rcfg.field_id_mode;

    // ************************************************************
    // Event handler
    // ************************************************************
    stc_state_t state_r;
    logic [2:0] skip_cnt_r;
    logic       repeated_r;
    logic       toggle_r;
    logic       start_r;
    logic       trig_hit;

    // Field triggers look at the field that is just starting
    always_comb begin
        case (tcfg.trigger_select)
            STC_TRIG_IMMEDIATE: trig_hit = 1'b1;
            STC_TRIG_VSYNC:     trig_hit = vsync_evt;
            STC_TRIG_FIELD0:    trig_hit = vsync_evt & ~in_fid;
            STC_TRIG_FIELD1:    trig_hit = vsync_evt & in_fid;
            default:            trig_hit = 1'b0;
        endcase
    end

    // Sequencing of the active task and handover to the other set
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_r      <= STC_WAIT;
            skip_cnt_r   <= STC_SKIP_ZERO;
            repeated_r   <= 1'b0;
            active_set_r <= STC_SET_A;
            start_r      <= 1'b0;
        end else begin
            start_r <= 1'b0;
            case (state_r)
                STC_WAIT: begin
                    skip_cnt_r <= STC_SKIP_ZERO;
                    if (trig_hit) begin
                        if (tcfg.field_skip == STC_SKIP_ZERO) begin
                            state_r <= STC_RUN;
                            start_r <= 1'b1;
                        end else begin
                            state_r <= STC_SKIP;
                        end
                    end
                end
                STC_SKIP: begin
                    // Each new field counts once toward the skip figure
                    if (vsync_evt) begin
                        if (skip_cnt_r + 3'h1 == tcfg.field_skip) begin
                            state_r <= STC_RUN;
                            start_r <= 1'b1;
                        end else begin
                            skip_cnt_r <= skip_cnt_r + 3'h1;
                        end
                    end
                end
                STC_RUN: begin
                    if (task_done) begin
                        state_r <= STC_DONE;
                    end
                end
                STC_DONE: begin
                    state_r <= STC_WAIT;
                    if (tcfg.task_repeat && !repeated_r) begin
                        repeated_r <= 1'b1;
                    end else begin
                        repeated_r   <= 1'b0;
                        active_set_r <= ~active_set_r;
                    end
                end
                default: state_r <= STC_WAIT;
            endcase
        end
    end

    // Task status flag flips on every activation, not tied to input fields
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            toggle_r <= 1'b0;
        end else if (start_r) begin
            toggle_r <= ~toggle_r;
        end
    end

    logic flag_now;
    logic out_fid_now;
    assign flag_now    = ~tcfg.task_flag_polarity ^ toggle_r;
    assign out_fid_now = tcfg.output_field_id_select ? flag_now : in_fid;

    // ************************************************************
    // Timing-code bits and vertical gate
    // ************************************************************
    logic v_now;
    logic f_hold_r, v_hold_r;
    assign v_now = internal_vgate ^ fcfg.vgate_polarity;

    // Held copies are refreshed only at output line start
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            f_hold_r <= 1'b0;
            v_hold_r <= 1'b0;
        end else if (output_line_start) begin
            f_hold_r <= out_fid_now;
            v_hold_r <= v_now;
        end
    end

    // ************************************************************
    // Chroma line pacing for sources without chroma on every line
    // ************************************************************
    logic [1:0] line_cnt_r;
    always_ff @(posedge clock) begin
        if (sys_rst || vsync_evt) begin
            line_cnt_r <= STC_LINE_ZERO;
        end else if (input_line_start) begin
            if (line_cnt_r == fcfg.chroma_line) begin
                line_cnt_r <= STC_LINE_ZERO;
            end else begin
                line_cnt_r <= line_cnt_r + 2'h1;
            end
        end
    end

    // ************************************************************
    // Registered outputs
    // ************************************************************
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            task_flag         <= 1'b0;
            output_field_id   <= 1'b0;
            code_bit7         <= 1'b0;
            code_f_bit        <= 1'b0;
            code_v_bit        <= 1'b0;
            vgate_output_pin  <= 1'b0;
            scaler_source     <= '0;
            request_enable    <= 1'b0;
            sampling_411      <= 1'b0;
            chroma_line_valid <= 1'b0;
        end else begin
            task_flag         <= flag_now;
            output_field_id   <= out_fid_now;
            code_bit7         <= ~tcfg.task_flag_polarity;
            code_f_bit        <= fcfg.fv_hold_sync ? f_hold_r : out_fid_now;
            code_v_bit        <= fcfg.fv_hold_sync ? v_hold_r : v_now;
            vgate_output_pin  <= v_now;
            scaler_source     <= fcfg.source_select;
            // Decoder as source needs continuous mode; requests never go to it
            request_enable    <= ~fcfg.request_mode_off & global_request_mode &
                                 src_is_xport;
            sampling_411      <= fcfg.sampling_scheme_select;
            chroma_line_valid <= (line_cnt_r == STC_LINE_ZERO);
        end
    end

    assign task_start = start_r;
    assign active_set = active_set_r;

    // ************************************************************
    // Register read-back
    // ************************************************************
    stc_status_t status_now;
    logic [7:0]  rdata_r;
    logic        rset;
    assign rset = set_of(reg_addr);

    // Status fields are the live flag levels, never latched for the read
    always_comb begin
        status_now                        = '0;
        status_now.formatter_error_flag   = output_rate_conflict;
        status_now.input_field_id_status  = in_fid;
        status_now.output_field_id_status = out_fid_now;
    end

    // Unmapped subaddresses read as zero
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rdata_r <= STC_RDATA_RST;
        end else if (reg_addr == STC_ADDR_STATUS) begin
            rdata_r <= status_now;
        end else if (reg_addr == STC_ADDR_TASK_A || reg_addr == STC_ADDR_TASK_B) begin
            rdata_r <= task_cfg_r[rset];
        end else if (reg_addr == STC_ADDR_FORMAT_A || reg_addr == STC_ADDR_FORMAT_B) begin
            rdata_r <= format_cfg_r[rset];
        end else if (reg_addr == STC_ADDR_REF_A || reg_addr == STC_ADDR_REF_B) begin
            rdata_r <= ref_cfg_r[rset];
        end else begin
            rdata_r <= STC_RDATA_RST;
        end
    end

    assign reg_rdata = rdata_r;

endmodule : stc_scaler_task_ctrl

// >>> tb/stc_scaler_task_ctrl_properties.sv
// Checker with the concurrent assertions of the task and input control block.
`timescale 1ns/1ps

module stc_props
    import stc_pkg::*;
(
    input wire logic       clock,
    input wire logic       sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_rdata,
    input wire logic       global_request_mode,
    input wire logic       output_rate_conflict,
    input wire logic       task_done,
    input wire logic       task_start,
    input wire logic       active_set,
    input wire logic       task_flag,
    input wire logic       code_bit7,
    input wire logic       output_field_id,
    input wire logic [1:0] scaler_source,
    input wire logic       request_enable
);
    // All checks live in the register clock domain
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    // Flag xor polarity is the toggle; it may only move two cycles after a start
    property p_toggle; $changed(task_flag ^ code_bit7) |-> $past(task_start, 2); endproperty
    a_toggle: assert property (p_toggle) else $error("task flag moved without start");
    property p_err; $past(reg_addr) == STC_ADDR_STATUS |-> reg_rdata[2] == $past(output_rate_conflict); endproperty
    a_err: assert property (p_err) else $error("error status bit wrong");
    property p_ofid; $past(reg_addr) == STC_ADDR_STATUS |-> reg_rdata[0] == output_field_id; endproperty
    a_ofid: assert property (p_ofid) else $error("output field status wrong");
    property p_upper; $past(reg_addr) == STC_ADDR_STATUS |-> reg_rdata[7:3] == 5'h00; endproperty
    a_upper: assert property (p_upper) else $error("status upper bits set");
    property p_unmap;
        !($past(reg_addr) inside {8'h8F, 8'h90, 8'h91, 8'h92, 8'hC0, 8'hC1, 8'hC2}) |-> reg_rdata == 8'h00;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_pulse; task_start |=> !task_start; endproperty
    a_pulse: assert property (p_pulse) else $error("start longer than one cycle");
    property p_swap; $changed(active_set) |-> $past(task_done, 2); endproperty
    a_swap: assert property (p_swap) else $error("set changed without finish");
    property p_req; request_enable |-> scaler_source[0] && $past(global_request_mode); endproperty
    a_req: assert property (p_req) else $error("request mode without cause");
endmodule : stc_props

bind stc_scaler_task_ctrl stc_props stc_props_inst (.clock, .sys_rst, .reg_addr, .reg_rdata,
    .global_request_mode, .output_rate_conflict, .task_done, .task_start, .active_set, .task_flag,
    .code_bit7, .output_field_id, .scaler_source, .request_enable);

// >>> tb/stc_xsrc_model.sv
// Behavioural X port video source driving the vertical and horizontal references.
`timescale 1ns/1ps

module stc_xsrc_model (
    input  wire logic xclk,
    output logic      ext_vertical_ref,
    output logic      ext_horizontal_ref
);
    // Continuous stream, never paced by requests
    initial begin
        ext_vertical_ref   = 1'b0;
        ext_horizontal_ref = 1'b1;
    end

    // One field: field ID settles on the horizontal line before the vertical edge
    task automatic field(input logic fid);
        @(posedge xclk);
        ext_horizontal_ref <= fid;
        repeat (2) @(posedge xclk);
        ext_vertical_ref <= 1'b1;
        repeat (4) @(posedge xclk);
        ext_vertical_ref <= 1'b0;
    endtask : field
endmodule : stc_xsrc_model

// >>> tb/stc_scaler_task_ctrl_bench.sv
// Self-checking testbench of the scaler task and input control block.
`timescale 1ns/1ps

module stc_scaler_task_ctrl_bench
    import stc_pkg::*;
;
    logic       clock, sys_rst, xclk, xclk_rst, reg_wr, global_request_mode, output_rate_conflict;
    logic       internal_vgate, task_done, task_start, active_set, task_flag, output_field_id, code_f_bit;
    logic       code_bit7, vgate_output_pin, request_enable, sampling_411, xv, xh, code_v_bit, chroma_line_valid;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [1:0] scaler_source;
    int         errors, cmp_count;
    localparam logic [7:0] ADR [6] = '{8'h90, 8'h91, 8'h92, 8'hC0, 8'hC1, 8'hC2};
    localparam logic [7:0] DAT [6] = '{8'h44, 8'hB1, 8'h5A, 8'h11, 8'h10, 8'h0A};

    stc_scaler_task_ctrl stc_scaler_task_ctrl_inst (.clock, .sys_rst, .xclk, .xclk_rst, .reg_addr,
        .reg_wr, .reg_wdata, .reg_rdata, .ext_vertical_ref(xv), .ext_horizontal_ref(xh),
        .decoder_vertical_signal(1'b0), .decoder_field_id(1'b0), .global_request_mode,
        .output_rate_conflict, .internal_vgate, .output_line_start(1'b0), .input_line_start(1'b0),
        .task_done, .task_start, .active_set, .task_flag, .output_field_id, .code_bit7,
        .code_f_bit, .code_v_bit, .vgate_output_pin, .scaler_source, .request_enable,
        .sampling_411, .chroma_line_valid);
    stc_xsrc_model stc_xsrc_model_inst (.xclk, .ext_vertical_ref(xv), .ext_horizontal_ref(xh));

    // Clocks unrelated in phase
    initial begin clock = 1'b0; forever #10 clock = ~clock; end
    initial begin xclk = 1'b0; #37; forever #80 xclk = ~xclk; end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
        @(negedge clock);
        reg_wr = 1'b0;
    endtask : wr
    // Read data is registered, so it settles one cycle after the address
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clock);
        reg_addr = a;
        repeat (2) @(negedge clock);
        check(reg_rdata, exp);
    endtask : rd
    // Bounded wait; a missed or unexpected start ends the run
    task automatic wait_start(input int n, input logic want);
        logic hit;
        hit = 1'b0;
        repeat (n) begin @(negedge clock); if (task_start === 1'b1) hit = 1'b1; end
        check({7'h00, hit}, {7'h00, want});
        if (hit !== want) tally_and_finish();
    endtask : wait_start
    task automatic pulse_done;
        @(negedge clock); task_done = 1'b1;
        @(negedge clock); task_done = 1'b0;
    endtask : pulse_done

    task automatic s_regs;
        for (int i = 0; i < 6; i++) wr(ADR[i], DAT[i]);
        wr(STC_ADDR_STATUS, 8'hFF);
        for (int i = 0; i < 6; i++) rd(ADR[i], DAT[i]);
        rd(8'h93, 8'h00);
    endtask : s_regs
    task automatic s_out;
        repeat (2) @(negedge clock);
        check({6'h00, scaler_source}, 8'h03);
        check({7'h00, sampling_411}, 8'h01);
        check({7'h00, vgate_output_pin}, 8'h00);
        check({7'h00, code_v_bit}, 8'h00);
        check({7'h00, chroma_line_valid}, 8'h01);
        check({7'h00, request_enable}, 8'h01);
        global_request_mode = 1'b0;
        repeat (2) @(negedge clock);
        check({7'h00, request_enable}, 8'h00);
    endtask : s_out
    task automatic s_status;
        output_rate_conflict = 1'b1;
        reg_addr = STC_ADDR_STATUS;
        repeat (2) @(negedge clock);
        check(reg_rdata & 8'hFC, 8'h04);
        output_rate_conflict = 1'b0;
        repeat (2) @(negedge clock);
        check(reg_rdata & 8'hFC, 8'h00);
    endtask : s_status
    task automatic s_tasks;
        logic f0;
        f0 = output_field_id;
        check({7'h00, code_bit7}, 8'h01);
        pulse_done();
        wait_start(8, 1'b1);
        check({6'h00, active_set, output_field_id}, {7'h00, ~f0});
        check({7'h00, code_f_bit}, {7'h00, output_field_id});
        pulse_done();
        wait_start(8, 1'b0);
        check({7'h00, active_set}, 8'h01);
        // Watch while the field runs; the start lands before the field task returns
        for (int i = 0; i < 2; i++) begin
            fork
                stc_xsrc_model_inst.field(i[0]);
                wait_start(60, 1'b0);
            join
        end
        fork
            stc_xsrc_model_inst.field(1'b0);
            wait_start(60, 1'b1);
        join
        wr(STC_ADDR_TASK_B, 8'h91);
        repeat (2) @(negedge clock);
        check({7'h00, code_bit7}, 8'h00);
    endtask : s_tasks

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish

    // Main sequence; both resets overlap several link clock edges
    initial begin
        {errors, cmp_count} = '0;
        {sys_rst, xclk_rst, reg_wr, reg_addr, reg_wdata, task_done} = {2'b11, 18'h00000};
        {global_request_mode, output_rate_conflict, internal_vgate} = 3'b101;
        repeat (25) @(negedge clock);
        {sys_rst, xclk_rst} = 2'b00;
        s_regs();
        s_out();
        s_status();
        s_tasks();
        tally_and_finish();
    end
endmodule : stc_scaler_task_ctrl_bench
